// ### verilog/lrmex_consts.svh
// Constants for the logic, rotate and multiply-accumulate execution unit.
// Assumes inclusion by bare name from the design files.
`ifndef LRMEX_CONSTS_SVH
`define LRMEX_CONSTS_SVH
`define LRMEX_WORD_W 32
`define LRMEX_SUM_W 33
`define LRMEX_FIELD_W 5
`define LRMEX_IMM_W 16
`define LRMEX_SAT_MIN 32'h80000000
`define LRMEX_SAT_MAX 32'h7FFFFFFF
`define LRMEX_ZERO_WORD 32'h00000000
`define LRMEX_ZERO_HALF 16'h0000
`define LRMEX_INS_BASE 6'h20
`define LRMEX_CR_LT 0
`define LRMEX_CR_GT 1
`define LRMEX_CR_EQ 2
`define LRMEX_CR_SO 3
`endif

// ### verilog/lrmex_pkg.sv
// Types shared by the execution unit.
// Assumes the constants header is on the include path.
`include "lrmex_consts.svh"
package lrmex_pkg;
  typedef enum logic [3:0] {
    LRMEX_OP_NMAC_SAT,
    LRMEX_OP_NOR,
    LRMEX_OP_OR,
    LRMEX_OP_ORC,
    LRMEX_OP_ORI,
    LRMEX_OP_ORIS,
    LRMEX_OP_ROT_INS,
    LRMEX_OP_ROT_AND,
    LRMEX_OP_INS_LEFT,
    LRMEX_OP_RET_CRIT,
    LRMEX_OP_RET_INT
  } lrmex_op_t;

  typedef struct packed {
    lrmex_op_t op;
    logic record_bit;
    logic overflow_enable;
    logic [4:0] shift_amount_field;
    logic [4:0] mask_begin_field;
    logic [4:0] mask_end_field;
    logic [15:0] immediate_field;
    logic [4:0] ins_length;
  } lrmex_cmd_t;

  typedef struct packed {
    logic [31:0] target_register;
    logic [31:0] first_operand_register;
    logic [31:0] second_operand_register;
    logic [31:0] source_register;
  } lrmex_opnd_t;

  typedef struct packed {
    logic [31:0] save_restore_pc;
    logic [31:0] save_restore_state;
    logic [31:0] critical_save_restore_pc;
    logic [31:0] critical_save_restore_state;
  } lrmex_save_t;
endpackage

// ### verilog/lrmex_unit.sv
// Execution datapath for the logic, rotate, negative multiply-accumulate and
// return-from-interrupt group. Assumes the decoder presents one command per
// valid cycle with operands already read; results appear one cycle later.
`timescale 1ns/1ns
`include "lrmex_consts.svh"
module lrmex_unit
  import lrmex_pkg::*;
#(
  parameter int WORD_W = `LRMEX_WORD_W
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_valid,
  input wire lrmex_cmd_t i_cmd,
  input wire lrmex_opnd_t i_opnd,
  input wire lrmex_save_t i_save,
  input wire logic i_privileged,
  input wire logic i_summary_overflow,
  output logic o_valid,
  output logic [31:0] o_result,
  output logic o_result_we,
  output logic [3:0] o_condition_field_zero,
  output logic o_condition_we,
  output logic o_overflow_flag,
  output logic o_summary_overflow,
  output logic o_overflow_we,
  output logic [31:0] o_next_pc,
  output logic [31:0] o_machine_state_register,
  output logic o_return_we,
  output logic o_context_sync,
  output logic o_privilege_fault,
  output logic o_nop
);

  // ********************************************************
  // Mask and rotate helpers
  // ********************************************************
  // Fields count bit 0 as the most significant bit, so index 31-k holds bit k.
  function automatic logic [31:0] make_mask(input logic [4:0] mb, input logic [4:0] me);
    logic [31:0] m;
    m = `LRMEX_ZERO_WORD;
    for (int k = 0; k < 32; k++) begin
      if (mb <= me) begin
        m[31-k] = (k >= int'(mb)) && (k <= int'(me));
      end else begin
        m[31-k] = (k >= int'(mb)) || (k <= int'(me));
      end
    end
    return m;
  endfunction

  function automatic logic [31:0] rotl(input logic [31:0] v, input logic [4:0] n);
    logic [63:0] d;
    d = {v, v} << n;
    return d[63:32];
  endfunction

  // ********************************************************
  // Combinational datapath
  // ********************************************************
  logic [31:0] next_result;
  logic next_result_we;
  logic next_ovf;
  logic [32:0] mac_sum;
  logic [31:0] mac_prod;
  logic [31:0] rot_mask;
  logic [31:0] rot_data;
  logic [4:0] eff_sh;
  logic [4:0] eff_mb;
  logic [4:0] eff_me;
  logic is_return;
  logic next_nop;

  always_comb begin
    logic signed [31:0] p;
    logic [5:0] ins_sh;
    ins_sh = `LRMEX_INS_BASE - {1'b0, i_cmd.mask_begin_field};
    p = $signed(i_opnd.first_operand_register[15:0])
      * $signed(i_opnd.second_operand_register[15:0]);
    mac_prod = -p;
    mac_sum = {mac_prod[31], mac_prod} + {i_opnd.target_register[31],
      i_opnd.target_register};
    eff_sh = i_cmd.shift_amount_field;
    eff_mb = i_cmd.mask_begin_field;
    eff_me = i_cmd.mask_end_field;
    if (i_cmd.op == LRMEX_OP_INS_LEFT) begin
      eff_sh = ins_sh[4:0];
      eff_me = i_cmd.mask_begin_field + i_cmd.ins_length - 5'h01;
    end
    rot_mask = make_mask(eff_mb, eff_me);
    rot_data = rotl(i_opnd.source_register, eff_sh);
    next_ovf = mac_sum[32] != mac_sum[31];
    next_result = `LRMEX_ZERO_WORD;
    next_result_we = 1'b1;
    is_return = 1'b0;
    unique case (i_cmd.op)
      LRMEX_OP_NMAC_SAT: begin
        if (!next_ovf) begin
          next_result = mac_sum[31:0];
        end else if (mac_sum[32]) begin
          next_result = `LRMEX_SAT_MIN;
        end else begin
          next_result = `LRMEX_SAT_MAX;
        end
      end
      LRMEX_OP_NOR: next_result = ~(i_opnd.source_register
        | i_opnd.second_operand_register);
      LRMEX_OP_OR: next_result = i_opnd.source_register
        | i_opnd.second_operand_register;
      LRMEX_OP_ORC: next_result = i_opnd.source_register
        | ~i_opnd.second_operand_register;
      LRMEX_OP_ORI: next_result = i_opnd.source_register
        | {`LRMEX_ZERO_HALF, i_cmd.immediate_field};
      LRMEX_OP_ORIS: next_result = i_opnd.source_register
        | {i_cmd.immediate_field, `LRMEX_ZERO_HALF};
      LRMEX_OP_ROT_INS, LRMEX_OP_INS_LEFT: next_result = (rot_data & rot_mask)
        | (i_opnd.first_operand_register & ~rot_mask);
      LRMEX_OP_ROT_AND: next_result = rot_data & rot_mask;
      LRMEX_OP_RET_CRIT, LRMEX_OP_RET_INT: begin
        next_result_we = 1'b0;
        is_return = 1'b1;
      end
      default: next_result_we = 1'b0;
    endcase
    // The no-operation form still writes zero through the normal path; next_nop only flags it on o_nop.
    next_nop = (i_cmd.op == LRMEX_OP_ORI) && (i_cmd.immediate_field == `LRMEX_ZERO_HALF)
      && (i_opnd.source_register == `LRMEX_ZERO_WORD);
  end

  // ********************************************************
  // Result and flag registers
  // ********************************************************
  logic sets_cr;
  assign sets_cr = i_cmd.record_bit && (i_cmd.op != LRMEX_OP_ORI)
    && (i_cmd.op != LRMEX_OP_ORIS) && !is_return;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_valid <= 1'b0;
      o_result <= `LRMEX_ZERO_WORD;
      o_result_we <= 1'b0;
      o_nop <= 1'b0;
    end else begin
      o_valid <= i_valid;
      o_result <= next_result;
      o_result_we <= i_valid && next_result_we;
      o_nop <= i_valid && next_nop;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_overflow_flag <= 1'b0;
      o_summary_overflow <= 1'b0;
      o_overflow_we <= 1'b0;
      o_condition_field_zero <= 4'h0;
      o_condition_we <= 1'b0;
    end else begin
      o_overflow_we <= i_valid && (i_cmd.op == LRMEX_OP_NMAC_SAT)
        && i_cmd.overflow_enable;
      o_overflow_flag <= next_ovf;
      o_summary_overflow <= i_summary_overflow || (i_cmd.overflow_enable && next_ovf
        && (i_cmd.op == LRMEX_OP_NMAC_SAT));
      o_condition_we <= i_valid && sets_cr;
      o_condition_field_zero[`LRMEX_CR_LT] <= next_result[31];
      o_condition_field_zero[`LRMEX_CR_GT] <= !next_result[31]
        && (next_result != `LRMEX_ZERO_WORD);
      o_condition_field_zero[`LRMEX_CR_EQ] <= next_result == `LRMEX_ZERO_WORD;
      o_condition_field_zero[`LRMEX_CR_SO] <= i_summary_overflow || (i_cmd.overflow_enable
        && next_ovf && (i_cmd.op == LRMEX_OP_NMAC_SAT));
    end
  end

  // ********************************************************
  // Return from interrupt
  // ********************************************************
  // A refused return raises a fault and keeps o_return_we low; the pc and state outputs still load.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_next_pc <= `LRMEX_ZERO_WORD;
      o_machine_state_register <= `LRMEX_ZERO_WORD;
      o_return_we <= 1'b0;
      o_context_sync <= 1'b0;
      o_privilege_fault <= 1'b0;
    end else begin
      o_return_we <= i_valid && is_return && i_privileged;
      o_context_sync <= i_valid && is_return && i_privileged;
      o_privilege_fault <= i_valid && is_return && !i_privileged;
      if (i_cmd.op == LRMEX_OP_RET_CRIT) begin
        o_next_pc <= i_save.critical_save_restore_pc;
        o_machine_state_register <= i_save.critical_save_restore_state;
      end else begin
        o_next_pc <= i_save.save_restore_pc;
        o_machine_state_register <= i_save.save_restore_state;
      end
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  chk_sat_clamp_max: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_valid && i_cmd.op == LRMEX_OP_NMAC_SAT && next_ovf && !mac_sum[32])
    |=> o_result == `LRMEX_SAT_MAX) else $error("clamp high wrong");
  chk_sat_clamp_min: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_valid && i_cmd.op == LRMEX_OP_NMAC_SAT && next_ovf && mac_sum[32])
    |=> o_result == `LRMEX_SAT_MIN) else $error("clamp low wrong");
  chk_mac_nowrap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_valid && i_cmd.op == LRMEX_OP_NMAC_SAT && !next_ovf)
    |=> o_result == $past(mac_sum[31:0])) else $error("mac sum wrong");
  chk_nor_value: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_valid && i_cmd.op == LRMEX_OP_NOR) |=> o_result_we
    && o_result == ~($past(i_opnd.source_register) | $past(i_opnd.second_operand_register)))
    else $error("nor wrong");
  chk_ori_nocr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_valid && i_cmd.op == LRMEX_OP_ORI) |=> !o_condition_we)
    else $error("ori touched condition");
  chk_rotand_mask: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_valid && i_cmd.op == LRMEX_OP_ROT_AND && i_cmd.mask_begin_field == 5'h00
    && i_cmd.mask_end_field == 5'h1F) |=> o_result == rotl($past(i_opnd.source_register),
    $past(i_cmd.shift_amount_field))) else $error("rotate and wrong");
  sequence s_ret_priv;
    i_valid && (i_cmd.op == LRMEX_OP_RET_INT) && i_privileged;
  endsequence
  sequence s_ret_done;
    o_return_we && o_context_sync && !o_result_we
    && o_next_pc == $past(i_save.save_restore_pc);
  endsequence
  chk_return_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_ret_priv |=> s_ret_done) else $error("return load wrong");
  chk_return_priv: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_valid && (i_cmd.op == LRMEX_OP_RET_CRIT) && !i_privileged)
    |=> o_privilege_fault && !o_return_we) else $error("unprivileged return");
  chk_cr_equal: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_condition_we |-> o_condition_field_zero[`LRMEX_CR_EQ] == (o_result == 32'h00000000))
    else $error("equal flag wrong");

  // ********************************************************
  // Further checks on every output
  // ********************************************************
  // One taken command of a given kind; the per-command response checks below start here except chk_cr_record, the global ones do not.
  sequence s_take(lrmex_op_t op);
    i_valid && (i_cmd.op == op);
  endsequence
  sequence s_crit_done;
    o_return_we && o_context_sync
    && o_next_pc == $past(i_save.critical_save_restore_pc)
    && o_machine_state_register == $past(i_save.critical_save_restore_state);
  endsequence
  chk_valid_follow: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_valid == $past(i_valid)) else $error("valid not delayed");
  chk_or_value: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_OR) |=> o_result_we
    && o_result == ($past(i_opnd.source_register) | $past(i_opnd.second_operand_register)))
    else $error("or wrong");
  chk_orc_value: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_ORC) |=> o_result_we
    && o_result == ($past(i_opnd.source_register) | ~$past(i_opnd.second_operand_register)))
    else $error("orc wrong");
  chk_ori_value: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_ORI) |=> o_result_we
    && o_result == ($past(i_opnd.source_register) | {16'h0000, $past(i_cmd.immediate_field)}))
    else $error("ori wrong");
  chk_oris_value: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_ORIS) |=> o_result_we && !o_condition_we
    && o_result == ($past(i_opnd.source_register) | {$past(i_cmd.immediate_field), 16'h0000}))
    else $error("oris wrong");
  chk_nop_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_ORI) ##0 (i_cmd.immediate_field == 16'h0000)
    ##0 (i_opnd.source_register == 32'h00000000) |=> o_nop && o_result == 32'h00000000)
    else $error("nop not flagged");
  chk_nop_only_ori: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_cmd.op != LRMEX_OP_ORI) |=> !o_nop) else $error("stray nop");
  chk_ins_full: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_ROT_INS) ##0 (i_cmd.mask_begin_field == 5'h00)
    ##0 (i_cmd.mask_end_field == 5'h1F) |=> o_result == rotl($past(i_opnd.source_register),
    $past(i_cmd.shift_amount_field))) else $error("insert full mask wrong");
  chk_ins_empty: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_ROT_INS) ##0 (i_opnd.source_register == 32'h00000000)
    |=> o_result == ($past(i_opnd.first_operand_register) & ~$past(rot_mask)))
    else $error("insert kept bits wrong");
  chk_mask_single: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_ROT_AND) ##0 (i_cmd.mask_begin_field == i_cmd.mask_end_field)
    |-> $onehot(rot_mask)) else $error("single bit mask wrong");
  chk_mask_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_ROT_AND) ##0 (i_cmd.mask_begin_field > i_cmd.mask_end_field)
    |-> rot_mask[31] && rot_mask[0]) else $error("mask does not wrap");
  chk_msb_first: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_ROT_AND) ##0 (i_cmd.mask_begin_field == 5'h00)
    ##0 (i_cmd.mask_end_field == 5'h00) |-> rot_mask == 32'h80000000)
    else $error("bit zero not msb");
  chk_insleft_rot: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_INS_LEFT) |-> eff_sh == 5'(6'h20 - {1'b0, i_cmd.mask_begin_field})
    && eff_mb == i_cmd.mask_begin_field) else $error("insert left rotate wrong");
  chk_crit_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_RET_CRIT) ##0 i_privileged |=> s_crit_done)
    else $error("critical return load wrong");
  chk_int_refuse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_RET_INT) ##0 !i_privileged |=> o_privilege_fault && !o_return_we
    && !o_context_sync) else $error("unprivileged return taken");
  chk_ret_nowrite: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_return_we |-> !o_result_we && !o_condition_we && o_context_sync)
    else $error("return wrote result");
  chk_ovf_enable: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_NMAC_SAT) ##0 i_cmd.overflow_enable |=> o_overflow_we
    && o_overflow_flag == $past(next_ovf)) else $error("overflow flag wrong");
  chk_ovf_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_cmd.op != LRMEX_OP_NMAC_SAT || !i_cmd.overflow_enable) |=> !o_overflow_we)
    else $error("overflow written without enable");
  chk_so_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_overflow_we && o_overflow_flag |-> o_summary_overflow)
    else $error("summary overflow not set");
  chk_mac_neg: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_take(LRMEX_OP_NMAC_SAT) ##0 (i_opnd.target_register == 32'h00000000)
    ##0 (i_opnd.first_operand_register[15:0] == 16'h0001)
    |=> o_result == -{{16{$past(i_opnd.second_operand_register[15])}},
    $past(i_opnd.second_operand_register[15:0])}) else $error("product not negated");
  chk_cr_record: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_valid && i_cmd.record_bit && i_cmd.op == LRMEX_OP_NOR |=> o_condition_we)
    else $error("record bit ignored");
  chk_cr_sign: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_condition_we |-> o_condition_field_zero[`LRMEX_CR_LT] == o_result[31]
    && o_condition_field_zero[`LRMEX_CR_GT] == (!o_result[31] && o_result != 32'h00000000))
    else $error("sign flags wrong");
  chk_cr_so: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_condition_we && o_overflow_we |-> o_condition_field_zero[`LRMEX_CR_SO]
    == o_summary_overflow) else $error("condition summary wrong");

endmodule

// ### sim/lrmex_dec_model.sv
// Model of the decoder and register-file read port feeding the unit.
// Assumes the bench hands it one command per cycle while i_go is high.
`timescale 1ns/1ns
module lrmex_dec_model
  import lrmex_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_go,
  input wire lrmex_cmd_t i_cmd,
  input wire lrmex_opnd_t i_opnd,
  input wire lrmex_save_t i_save,
  input wire logic [1:0] i_state,
  output logic o_valid,
  output lrmex_cmd_t o_cmd,
  output lrmex_opnd_t o_opnd,
  output lrmex_save_t o_save,
  output logic [1:0] o_state
);
  // Idle read ports show flipped data, so a stale operand is never mistaken for a live one.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_valid <= 1'b0;
      o_cmd <= '0;
      o_opnd <= '0;
      o_save <= '0;
      o_state <= 2'h0;
    end else begin
      o_valid <= i_go;
      o_cmd <= i_cmd;
      o_opnd <= i_go ? i_opnd : ~o_opnd;
      o_save <= i_go ? i_save : ~o_save;
      o_state <= i_state;
    end
  end
endmodule

// ### sim/logic_rotate_mac_exec_unit_tb.sv
// Self-checking bench for the execution unit with a decoder model in front.
// Assumes the unit answers each command one cycle after taking it.
`timescale 1ns/1ns
`include "lrmex_consts.svh"
module logic_rotate_mac_exec_unit_tb
  import lrmex_pkg::*;
;
  typedef struct packed {
    logic vld, res_we, cond_we, ov_we, ov, so, ret_we, sync, fault, nop;
    logic [3:0] cond;
    logic [31:0] res, pc, machine_state_register;
  } lrmex_exp_t;
  logic i_clk, i_rst_b, go, m_valid;
  logic [1:0] state, m_state;
  lrmex_cmd_t cmd, m_cmd;
  lrmex_opnd_t opnd, m_opnd;
  lrmex_save_t save, m_save;
  logic o_valid, o_result_we, o_condition_we, o_overflow_flag, o_summary_overflow;
  logic o_overflow_we, o_return_we, o_context_sync, o_privilege_fault, o_nop;
  logic [31:0] o_result, o_next_pc, o_machine_state_register;
  logic [3:0] o_condition_field_zero;
  lrmex_exp_t expq[$];
  int err_total, total_checks, k;
  integer seed = 32'hCEA5CB21;
  lrmex_dec_model model (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_go(go), .i_cmd(cmd),
    .i_opnd(opnd), .i_save(save), .i_state(state), .o_valid(m_valid), .o_cmd(m_cmd),
    .o_opnd(m_opnd), .o_save(m_save), .o_state(m_state));
  lrmex_unit dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_valid(m_valid), .i_cmd(m_cmd),
    .i_opnd(m_opnd), .i_save(m_save), .i_privileged(m_state[1]),
    .i_summary_overflow(m_state[0]), .o_valid(o_valid), .o_result(o_result),
    .o_result_we(o_result_we), .o_condition_field_zero(o_condition_field_zero),
    .o_condition_we(o_condition_we), .o_overflow_flag(o_overflow_flag),
    .o_summary_overflow(o_summary_overflow), .o_overflow_we(o_overflow_we),
    .o_next_pc(o_next_pc), .o_machine_state_register(o_machine_state_register),
    .o_return_we(o_return_we), .o_context_sync(o_context_sync),
    .o_privilege_fault(o_privilege_fault), .o_nop(o_nop));
  // ********************
  // Expectation model
  // ********************
  function automatic lrmex_exp_t expect_of(lrmex_cmd_t c, lrmex_opnd_t d, lrmex_save_t s,
    logic [1:0] st);
    lrmex_exp_t e;
    logic [31:0] m, r, rs, rb;
    logic signed [31:0] p;
    logic [32:0] t;
    logic [4:0] mb, me, sh;
    e = '0;
    e.vld = 1'b1;
    rs = d.source_register;
    rb = d.second_operand_register;
    mb = c.mask_begin_field;
    me = c.mask_end_field;
    sh = c.shift_amount_field;
    if (c.op == LRMEX_OP_INS_LEFT) begin
      me = mb + c.ins_length - 5'h01;
      sh = 5'h00 - mb;
    end
    for (int i = 0; i < 32; i++) begin
      m[31 - i] = (mb <= me) ? (i >= mb && i <= me) : (i >= mb || i <= me);
    end
    r = 32'(({rs, rs} << sh) >> 32);
    p = $signed(d.first_operand_register[15:0]) * $signed(rb[15:0]);
    t = {d.target_register[31], d.target_register} - {p[31], p};
    case (c.op)
      LRMEX_OP_NMAC_SAT: begin
        e.res = (t[32] ^ t[31]) ? (t[32] ? `LRMEX_SAT_MIN : `LRMEX_SAT_MAX) : t[31:0];
        e.ov_we = c.overflow_enable;
        e.ov = c.overflow_enable & (t[32] ^ t[31]);
        e.so = c.overflow_enable & (st[0] | e.ov);
      end
      LRMEX_OP_NOR: e.res = ~(rs | rb);
      LRMEX_OP_OR: e.res = rs | rb;
      LRMEX_OP_ORC: e.res = rs | ~rb;
      LRMEX_OP_ORI: e.res = rs | {16'h0000, c.immediate_field};
      LRMEX_OP_ORIS: e.res = rs | {c.immediate_field, 16'h0000};
      LRMEX_OP_ROT_AND: e.res = r & m;
      LRMEX_OP_ROT_INS, LRMEX_OP_INS_LEFT: e.res = (r & m) | (d.first_operand_register & ~m);
      default: begin
        e.ret_we = st[1];
        e.sync = st[1];
        e.fault = ~st[1];
        e.pc = !st[1] ? 32'h0 : c.op == LRMEX_OP_RET_CRIT ? s.critical_save_restore_pc :
          s.save_restore_pc;
        e.machine_state_register = !st[1] ? 32'h0 : c.op == LRMEX_OP_RET_CRIT ? s.critical_save_restore_state :
          s.save_restore_state;
        return e;
      end
    endcase
    e.res_we = 1'b1;
    e.cond_we = c.record_bit && c.op != LRMEX_OP_ORI && c.op != LRMEX_OP_ORIS;
    if (e.cond_we) begin
      e.cond = {e.ov_we ? e.so : st[0], e.res == 0, $signed(e.res) > 0, $signed(e.res) < 0};
    end
    e.nop = c.op == LRMEX_OP_ORI && c.immediate_field == 16'h0000 && rs == 32'h0;
    return e;
  endfunction
  function automatic lrmex_exp_t act_of();
    lrmex_exp_t a;
    a = '0;
    a.vld = o_valid;
    a.res_we = o_result_we;
    a.cond_we = o_condition_we;
    a.ov_we = o_overflow_we;
    a.ret_we = o_return_we;
    a.sync = o_context_sync;
    a.fault = o_privilege_fault;
    a.nop = o_nop;
    if (o_result_we) a.res = o_result;
    if (o_condition_we) a.cond = o_condition_field_zero;
    if (o_overflow_we) {a.ov, a.so} = {o_overflow_flag, o_summary_overflow};
    if (o_return_we) {a.pc, a.machine_state_register} = {o_next_pc, o_machine_state_register};
    return a;
  endfunction
  // ********************
  // Drivers and checks
  // ********************
  task automatic chk(lrmex_exp_t e, lrmex_exp_t a);
    total_checks++;
    if (a !== e) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task automatic issue(lrmex_cmd_t c, lrmex_opnd_t d, lrmex_save_t s, logic [1:0] st);
    @(posedge i_clk);
    go <= 1'b1;
    cmd <= c;
    opnd <= d;
    save <= s;
    state <= st;
    expq.push_back(expect_of(c, d, s, st));
  endtask
  task automatic rand_issue(int op);
    lrmex_cmd_t c;
    lrmex_opnd_t d;
    c = $bits(c)'({$random(seed), $random(seed)});
    d = {$random(seed), $random(seed), $random(seed), $random(seed)};
    c.op = lrmex_op_t'(op);
    c.ins_length = 5'(1 + $unsigned($random(seed)) % (32 - c.mask_begin_field -
      (c.mask_begin_field == 0)));
    if ($random(seed) & 1) d.target_register = {d.target_register[31], {31{~d.target_register[31]}}};
    issue(c, d, {$random(seed), $random(seed), $random(seed), $random(seed)}, 2'($random(seed)));
  endtask
  task automatic dir(lrmex_op_t op, logic [31:0] t, a, b, s, logic [4:0] mb, me, sh,
    logic [15:0] im, logic [1:0] st);
    issue({op, 2'b11, sh, mb, me, im, me}, {t, a, b, s}, {32'h1111, 32'h2222, 32'h3333, 32'h4444}, st);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(negedge i_clk) begin
    if (i_rst_b && o_valid !== 1'b0) begin
      chk(expq.size() ? expq.pop_front() : '1, act_of());
    end
  end
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    {i_rst_b, go, cmd, opnd, save, state} = '0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    chk('0, act_of());
    i_rst_b <= 1'b1;
    dir(LRMEX_OP_NMAC_SAT, 32'h7FFFFFFF, 32'h1, 32'hFFFF, 0, 0, 0, 0, 0, 2'b01);
    dir(LRMEX_OP_NMAC_SAT, 32'h80000000, 32'h1, 32'h1, 0, 0, 0, 0, 0, 2'b00);
    dir(LRMEX_OP_NMAC_SAT, 32'h0, 32'h8000, 32'h8000, 0, 0, 0, 0, 0, 2'b00);
    dir(LRMEX_OP_ORI, 0, 0, 0, 0, 0, 0, 0, 16'h0000, 2'b00);
    dir(LRMEX_OP_ORIS, 0, 0, 0, 32'h5, 0, 0, 0, 16'hA5C3, 2'b00);
    dir(LRMEX_OP_ROT_AND, 0, 0, 0, 32'h80000001, 5'd30, 5'd1, 5'd1, 0, 0);
    dir(LRMEX_OP_ROT_INS, 0, 32'hFFFF0000, 0, 32'h1234, 5'd7, 5'd7, 5'd3, 0, 0);
    dir(LRMEX_OP_INS_LEFT, 0, 32'h0, 0, 32'hF0000000, 5'd0, 5'd4, 0, 0, 0);
    dir(LRMEX_OP_RET_CRIT, 0, 0, 0, 0, 0, 0, 0, 0, 2'b10);
    dir(LRMEX_OP_RET_INT, 0, 0, 0, 0, 0, 0, 0, 0, 2'b10);
    dir(LRMEX_OP_RET_INT, 0, 0, 0, 0, 0, 0, 0, 0, 2'b01);
    for (k = 0; k < 440; k++) begin
      rand_issue(k % 11);
      if (k % 7 == 6) begin
        @(posedge i_clk);
        go <= 1'b0;
      end
    end
    @(posedge i_clk);
    go <= 1'b0;
    for (k = 0; k < 10 && expq.size() != 0; k++) @(posedge i_clk);
    if (expq.size() != 0) err_total++;
    report_and_stop();
  end
endmodule
